// file: pkg/arf_pkg.sv
// package: register selectors, widths, flag positions and reset values for the register file
package arf_pkg;
  localparam int DATA_W = 32;
  localparam int SEL_W  = 16;

  // general register indices
  localparam logic [2:0] GPR_ACC  = 3'h0;
  localparam logic [2:0] GPR_CNT  = 3'h1;
  localparam logic [2:0] GPR_IOP  = 3'h2;
  localparam logic [2:0] GPR_BASE = 3'h3;
  localparam logic [2:0] GPR_SP   = 3'h4;
  localparam logic [2:0] GPR_BP   = 3'h5;
  localparam logic [2:0] GPR_SI   = 3'h6;
  localparam logic [2:0] GPR_DI   = 3'h7;

  // segment register indices
  localparam logic [2:0] SEG_EXTRA = 3'h0;
  localparam logic [2:0] SEG_CODE  = 3'h1;
  localparam logic [2:0] SEG_STACK = 3'h2;
  localparam logic [2:0] SEG_DATA  = 3'h3;
  localparam logic [2:0] SEG_THIRD = 3'h4;
  localparam logic [2:0] SEG_FOURTH = 3'h5;
  localparam int         SEG_NUM   = 6;

  // access width of a general register port
  typedef enum logic [1:0] {ARF_W32, ARF_W16, ARF_LO8, ARF_HI8} arf_width_e;

  // group transfer operations on the flags register
  typedef enum logic [2:0] {
    ARF_FL_NONE,
    ARF_FL_LOAD_TO_ACC,
    ARF_FL_STORE_FROM_ACC,
    ARF_FL_PUSH_WORD,
    ARF_FL_PUSH_DWORD,
    ARF_FL_POP_WORD,
    ARF_FL_POP_DWORD
  } arf_flop_e;

  // flag positions
  localparam int FL_CARRY  = 0;
  localparam int FL_PARITY = 2;
  localparam int FL_ADJUST = 4;
  localparam int FL_ZERO   = 6;
  localparam int FL_SIGN   = 7;
  localparam int FL_DIR    = 10;
  localparam int FL_OVF    = 11;

  localparam logic [31:0] FLAGS_RESET   = 32'h0000_0002;
  localparam logic [31:0] FLAGS_RSVD    = 32'hffc0_802a;
  localparam logic [31:0] FLAGS_STATUS  = 32'h0000_08d5;
  localparam logic [31:0] FLAGS_LOBYTE  = 32'h0000_00d5;
  localparam logic [31:0] FLAGS_WORD    = 32'h0000_ffff;
  localparam logic [31:0] GPR_RESET     = 32'h0000_0000;
  localparam logic [15:0] SEG_RESET     = 16'h0000;
  localparam logic [31:0] IP_RESET      = 32'h0000_0000;
endpackage : arf_pkg

// file: core/arf_register_file.sv
// architectural register file: general registers, segment selectors, flags register
`timescale 1ns/1ps
module arf_register_file #(
  parameter int NUM_GPR = 8
) (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire logic                    init,
  // general register read port
  input  wire logic [2:0]              gprRdSel,
  input  wire arf_pkg::arf_width_e     gprRdWidth,
  output logic [31:0]                  gprRdData,
  // general register write port
  input  wire logic                    gprWrEn,
  input  wire logic [2:0]              gprWrSel,
  input  wire arf_pkg::arf_width_e     gprWrWidth,
  input  wire logic [31:0]             gprWrData,
  output logic                         gprWrReject,
  // segment selector port
  input  wire logic [2:0]              segRdSel,
  output logic [15:0]                  segRdData,
  input  wire logic                    segWrEn,
  input  wire logic [2:0]              segWrSel,
  input  wire logic [15:0]             segWrData,
  output logic                         segWrReject,
  // control transfer: code selector and instruction pointer
  input  wire logic                    xferEn,
  input  wire logic [15:0]             xferCodeSel,
  input  wire logic [31:0]             xferIp,
  input  wire logic                    ipWrEn,
  input  wire logic [31:0]             ipWrData,
  output logic [15:0]                  fetchSel,
  output logic [31:0]                  fetchOffset,
  // string and stack addressing views
  output logic [15:0]                  stackSel,
  output logic [31:0]                  stackPtr,
  output logic [31:0]                  framePtr,
  output logic [31:0]                  loopCount,
  output logic [31:0]                  srcIndex,
  output logic [31:0]                  dstIndex,
  output logic [15:0]                  srcSel,
  output logic [15:0]                  dstSel,
  output logic                         strDecrement,
  // flags group transfers
  input  wire arf_pkg::arf_flop_e      flagOp,
  input  wire logic [31:0]             flagPopData,
  output logic [31:0]                  flagPushData,
  output logic                         flagPushValid,
  // arithmetic status update from execution
  input  wire logic                    statusWrEn,
  input  wire logic [31:0]             statusWrData,
  input  wire logic                    dirWrEn,
  input  wire logic                    dirWrData,
  // task switch and handler entry
  input  wire logic                    taskSuspend,
  input  wire logic                    taskLoad,
  input  wire logic [31:0]             taskFlagsIn,
  input  wire logic                    handlerCall,
  input  wire logic                    handlerViaTask,
  output logic [31:0]                  taskFlagsOut,
  output logic                         taskFlagsOutValid,
  output logic [31:0]                  flagsView
);
  typedef struct packed {
    logic [NUM_GPR-1:0][31:0]          gpr;
    logic [arf_pkg::SEG_NUM-1:0][15:0] seg;
    logic [31:0]                       ip;
    logic [31:0]                       flags;
    logic [31:0]                       pushData;
    logic                              pushValid;
    logic [31:0]                       taskOut;
    logic                              taskOutValid;
    logic [31:0]                       gprRd;
    logic [15:0]                       segRd;
    logic                              gprRej;
    logic                              segRej;
  } arf_state_s;

  arf_state_s state_reg;
  arf_state_s state_next;

  // only the four data-capable registers have byte names
  function automatic logic byteCapable(input logic [2:0] sel);
    byteCapable = (sel == arf_pkg::GPR_ACC) || (sel == arf_pkg::GPR_BASE) ||
                  (sel == arf_pkg::GPR_CNT) || (sel == arf_pkg::GPR_IOP);
  endfunction : byteCapable

  // merge an alias write into the full register
  function automatic logic [31:0] mergeAlias(input logic [31:0] old, input logic [31:0] wd,
                                             input arf_pkg::arf_width_e w);
    case (w)
      arf_pkg::ARF_W32: mergeAlias = wd;
      arf_pkg::ARF_W16: mergeAlias = {old[31:16], wd[15:0]};
      arf_pkg::ARF_LO8: mergeAlias = {old[31:8], wd[7:0]};
      arf_pkg::ARF_HI8: mergeAlias = {old[31:16], wd[7:0], old[7:0]};
      default:          mergeAlias = old;
    endcase
  endfunction : mergeAlias

  // reserved bits forced so software-visible values stay defined
  function automatic logic [31:0] cleanFlags(input logic [31:0] v);
    cleanFlags = (v & ~arf_pkg::FLAGS_RSVD) | arf_pkg::FLAGS_RESET;
  endfunction : cleanFlags

  function automatic logic aliasLegal(input logic [2:0] sel, input arf_pkg::arf_width_e w);
    aliasLegal = (w == arf_pkg::ARF_W32) || (w == arf_pkg::ARF_W16) || byteCapable(sel);
  endfunction : aliasLegal

  always_comb begin
    logic [31:0] rd;
    rd = state_reg.gpr[gprRdSel];
    state_next = state_reg;
    state_next.pushValid = 1'b0;
    state_next.taskOutValid = 1'b0;
    state_next.gprRej = 1'b0;
    state_next.segRej = 1'b0;

    // registered read data
    case (gprRdWidth)
      arf_pkg::ARF_W32: state_next.gprRd = rd;
      arf_pkg::ARF_W16: state_next.gprRd = {16'h0000, rd[15:0]};
      arf_pkg::ARF_LO8: state_next.gprRd = byteCapable(gprRdSel) ? {24'h000000, rd[7:0]} : 32'h0000_0000;
      arf_pkg::ARF_HI8: state_next.gprRd = byteCapable(gprRdSel) ? {24'h000000, rd[15:8]} : 32'h0000_0000;
      default:          state_next.gprRd = 32'h0000_0000;
    endcase
    state_next.segRd = (segRdSel < 3'(arf_pkg::SEG_NUM)) ? state_reg.seg[segRdSel] : 16'h0000;

    // general register writes; byte names absent on index and pointer registers
    if (gprWrEn) begin
      if (aliasLegal(gprWrSel, gprWrWidth)) begin
        state_next.gpr[gprWrSel] = mergeAlias(state_reg.gpr[gprWrSel], gprWrData, gprWrWidth);
      end else begin
        state_next.gprRej = 1'b1;
      end
    end

    // selector loads: code selector only through control transfer
    if (segWrEn) begin
      if (segWrSel == arf_pkg::SEG_CODE || segWrSel >= 3'(arf_pkg::SEG_NUM)) begin
        state_next.segRej = 1'b1;
      end else begin
        state_next.seg[segWrSel] = segWrData;
      end
    end
    if (ipWrEn) begin
      state_next.ip = ipWrData;
    end
    if (xferEn) begin
      state_next.seg[arf_pkg::SEG_CODE] = xferCodeSel;
      state_next.ip = xferIp;
    end

    // execution updates single flags; never the whole register
    if (statusWrEn) begin
      state_next.flags = (state_next.flags & ~arf_pkg::FLAGS_STATUS) |
                         (statusWrData & arf_pkg::FLAGS_STATUS);
    end
    if (dirWrEn) begin
      state_next.flags[arf_pkg::FL_DIR] = dirWrData;
    end

    // group transfers through accumulator byte or the stack
    case (flagOp)
      arf_pkg::ARF_FL_LOAD_TO_ACC: begin
        state_next.gpr[arf_pkg::GPR_ACC][15:8] = state_reg.flags[7:0];
      end
      arf_pkg::ARF_FL_STORE_FROM_ACC: begin
        state_next.flags = (state_next.flags & ~arf_pkg::FLAGS_LOBYTE) |
                           ({24'h000000, state_reg.gpr[arf_pkg::GPR_ACC][15:8]} & arf_pkg::FLAGS_LOBYTE);
      end
      arf_pkg::ARF_FL_PUSH_WORD: begin
        state_next.pushData = {16'h0000, state_reg.flags[15:0]};
        state_next.pushValid = 1'b1;
      end
      arf_pkg::ARF_FL_PUSH_DWORD: begin
        state_next.pushData = state_reg.flags;
        state_next.pushValid = 1'b1;
      end
      arf_pkg::ARF_FL_POP_WORD: begin
        state_next.flags = cleanFlags((state_reg.flags & ~arf_pkg::FLAGS_WORD) |
                                      (flagPopData & arf_pkg::FLAGS_WORD));
      end
      arf_pkg::ARF_FL_POP_DWORD: begin
        state_next.flags = cleanFlags(flagPopData);
      end
      default: begin
      end
    endcase

    // handler entry: stack push, or state-segment save when via a task
    if (handlerCall && !handlerViaTask) begin
      state_next.pushData = state_reg.flags;
      state_next.pushValid = 1'b1;
    end
    if (taskSuspend || (handlerCall && handlerViaTask)) begin
      state_next.taskOut = state_reg.flags;
      state_next.taskOutValid = 1'b1;
    end
    // new task data wins over any same-cycle update except init
    if (taskLoad) begin
      state_next.flags = cleanFlags(taskFlagsIn);
    end
    state_next.flags = cleanFlags(state_next.flags);

    // init acts as a synchronous reinitialisation of the flags
    if (init) begin
      state_next.flags = arf_pkg::FLAGS_RESET;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg.gpr          <= '0;
      state_reg.seg          <= '0;
      state_reg.ip           <= arf_pkg::IP_RESET;
      state_reg.flags        <= arf_pkg::FLAGS_RESET;
      state_reg.pushData     <= 32'h0000_0000;
      state_reg.pushValid    <= 1'b0;
      state_reg.taskOut      <= 32'h0000_0000;
      state_reg.taskOutValid <= 1'b0;
      state_reg.gprRd        <= 32'h0000_0000;
      state_reg.segRd        <= arf_pkg::SEG_RESET;
      state_reg.gprRej       <= 1'b0;
      state_reg.segRej       <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign gprRdData         = state_reg.gprRd;
  assign segRdData         = state_reg.segRd;
  assign gprWrReject       = state_reg.gprRej;
  assign segWrReject       = state_reg.segRej;
  assign fetchSel          = state_reg.seg[arf_pkg::SEG_CODE];
  assign fetchOffset       = state_reg.ip;
  assign stackSel          = state_reg.seg[arf_pkg::SEG_STACK];
  assign stackPtr          = state_reg.gpr[arf_pkg::GPR_SP];
  assign framePtr          = state_reg.gpr[arf_pkg::GPR_BP];
  assign loopCount         = state_reg.gpr[arf_pkg::GPR_CNT];
  assign srcIndex          = state_reg.gpr[arf_pkg::GPR_SI];
  assign dstIndex          = state_reg.gpr[arf_pkg::GPR_DI];
  assign srcSel            = state_reg.seg[arf_pkg::SEG_DATA];
  assign dstSel            = state_reg.seg[arf_pkg::SEG_EXTRA];
  assign strDecrement      = state_reg.flags[arf_pkg::FL_DIR];
  assign flagPushData      = state_reg.pushData;
  assign flagPushValid     = state_reg.pushValid;
  assign taskFlagsOut      = state_reg.taskOut;
  assign taskFlagsOutValid = state_reg.taskOutValid;
  assign flagsView         = state_reg.flags;
endmodule : arf_register_file

// file: testbench/arf_register_file_monitor.sv
// checker: port timing relations of the register file
`timescale 1ns/1ps
module arf_register_file_monitor (
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic [31:0]        flagsView,
  input wire logic               segWrEn,
  input wire logic [2:0]         segWrSel,
  input wire logic               segWrReject,
  input wire logic               gprWrEn,
  input wire logic [2:0]         gprWrSel,
  input wire arf_pkg::arf_width_e gprWrWidth,
  input wire logic               gprWrReject,
  input wire logic               xferEn,
  input wire logic [15:0]        xferCodeSel,
  input wire logic [15:0]        fetchSel,
  input wire logic               strDecrement,
  input wire logic               handlerCall,
  input wire logic               handlerViaTask,
  input wire logic               flagPushValid,
  input wire logic [31:0]        flagPushData,
  input wire logic               taskSuspend,
  input wire logic               taskFlagsOutValid,
  input wire logic [31:0]        taskFlagsOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  rsvd_fixed_a: assert property ((flagsView & arf_pkg::FLAGS_RSVD) == arf_pkg::FLAGS_RESET)
    else $error("reserved flag bits moved");
  code_reject_a: assert property (segWrEn && segWrSel == arf_pkg::SEG_CODE |=> segWrReject)
    else $error("code selector write not refused");
  data_accept_a: assert property (segWrEn && segWrSel != 3'h1 && segWrSel < 3'h6 |=> !segWrReject)
    else $error("data or stack selector write refused");
  byte_reject_a: assert property (gprWrEn && gprWrSel[2] && gprWrWidth inside {arf_pkg::ARF_LO8, arf_pkg::ARF_HI8}
    |=> gprWrReject)
    else $error("byte write to pointer register not refused");
  fetch_load_a: assert property (xferEn |=> fetchSel == $past(xferCodeSel))
    else $error("fetch selector not loaded by transfer");
  dir_view_a: assert property (strDecrement == flagsView[arf_pkg::FL_DIR])
    else $error("decrement output differs from direction flag");
  handler_push_a: assert property (handlerCall && !handlerViaTask |=> flagPushValid && flagPushData == $past(flagsView))
    else $error("handler call did not push flags");
  suspend_save_a: assert property (taskSuspend |=> taskFlagsOutValid && taskFlagsOut == $past(flagsView))
    else $error("suspend did not save flags");
  cover property (handlerCall ##1 flagPushValid);
  cover property (segWrEn && segWrSel == arf_pkg::SEG_CODE ##1 segWrReject);
  cover property (taskSuspend ##1 taskFlagsOutValid);
endmodule : arf_register_file_monitor
bind arf_register_file arf_register_file_monitor mon_inst (.clk, .rstn, .flagsView, .segWrEn, .segWrSel,
  .segWrReject, .gprWrEn, .gprWrSel, .gprWrWidth, .gprWrReject, .xferEn, .xferCodeSel, .fetchSel, .strDecrement,
  .handlerCall, .handlerViaTask, .flagPushValid, .flagPushData, .taskSuspend, .taskFlagsOutValid, .taskFlagsOut);

// file: testbench/arf_exec_model.sv
// partner: procedure stack top and task state segment flag slot
`timescale 1ns/1ps
module arf_exec_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        flagPushValid,
  input  wire logic [31:0] flagPushData,
  input  wire logic        taskFlagsOutValid,
  input  wire logic [31:0] taskFlagsOut,
  output logic      [31:0] stackTop,
  output logic      [31:0] tssFlags
);
  // tssFlags feeds the next task load back in
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      {stackTop, tssFlags} <= '0;
    end else begin
      if (flagPushValid) stackTop <= flagPushData;
      if (taskFlagsOutValid) tssFlags <= taskFlagsOut;
    end
  end
endmodule : arf_exec_model

// file: testbench/arf_register_file_tb.sv
// testbench: register file with note queue and scoreboard
`timescale 1ns/1ps
module arf_register_file_tb;
  logic clk, rstn, init, gprWrEn, gprWrReject, segWrEn, segWrReject, xferEn, ipWrEn, flagPushValid, strDecrement;
  logic statusWrEn, dirWrEn, dirWrData, taskSuspend, taskLoad, handlerCall, handlerViaTask, taskFlagsOutValid;
  logic [2:0] gprRdSel, gprWrSel, segRdSel, segWrSel;
  logic [15:0] segRdData, segWrData, xferCodeSel, fetchSel, stackSel, srcSel, dstSel;
  logic [31:0] gprRdData, gprWrData, xferIp, ipWrData, fetchOffset, stackPtr, framePtr, loopCount, srcIndex;
  logic [31:0] dstIndex, flagPopData, flagPushData, statusWrData, taskFlagsIn, taskFlagsOut, flagsView, stackTop;
  arf_pkg::arf_width_e gprRdWidth, gprWrWidth;
  arf_pkg::arf_flop_e flagOp;
  logic [31:0] gpr [8], fl, d, sv, expQ [$];
  logic [15:0] seg [8];
  int kQ [$];
  int vmap [5] = '{1, 6, 7, 4, 5};
  int miscompares = 0, n_tests = 0, cyc = 0;

  arf_register_file arf_register_file_inst (.clk, .rstn, .init, .gprRdSel, .gprRdWidth, .gprRdData, .gprWrEn,
    .gprWrSel, .gprWrWidth, .gprWrData, .gprWrReject, .segRdSel, .segRdData, .segWrEn, .segWrSel, .segWrData,
    .segWrReject, .xferEn, .xferCodeSel, .xferIp, .ipWrEn, .ipWrData, .fetchSel, .fetchOffset, .stackSel, .stackPtr,
    .framePtr, .loopCount, .srcIndex, .dstIndex, .srcSel, .dstSel, .strDecrement, .flagOp, .flagPopData,
    .flagPushData, .flagPushValid, .statusWrEn, .statusWrData, .dirWrEn, .dirWrData, .taskSuspend, .taskLoad,
    .taskFlagsIn, .handlerCall, .handlerViaTask, .taskFlagsOut, .taskFlagsOutValid, .flagsView);
  arf_exec_model arf_exec_model_inst (.clk, .rstn, .flagPushValid, .flagPushData, .taskFlagsOutValid,
    .taskFlagsOut, .stackTop, .tssFlags(taskFlagsIn));

  function automatic logic [31:0] pick(input int k);
    case (k)
      0: return gprRdData;
      1: return {16'h0, segRdData};
      2: return flagsView;
      3: return {fetchSel, fetchOffset[15:0]};
      4: return flagPushData;
      5: return taskFlagsOut;
      6: return {30'h0, gprWrReject, segWrReject};
      7: return {stackSel, srcSel};
      8: return {dstSel, 16'h0};
      9: return loopCount;
      10: return srcIndex;
      11: return dstIndex;
      12: return stackPtr;
      13: return framePtr;
      14: return {31'h0, strDecrement};
      15: return flagPushData & arf_pkg::FLAGS_WORD;
      default: return stackTop;
    endcase
  endfunction : pick

  function automatic logic [31:0] aview(input logic [31:0] v, input int i, input int w);
    case (w)
      0: return v;
      1: return {16'h0, v[15:0]};
      2: return (i < 4) ? {24'h0, v[7:0]} : 32'h0;
      default: return (i < 4) ? {24'h0, v[15:8]} : 32'h0;
    endcase
  endfunction : aview

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  task automatic close_out();
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // one note per falling edge keeps the queue in step with the outputs
  task automatic note(input int k, input logic [31:0] e);
    kQ.push_back(k);
    expQ.push_back(e);
    @(negedge clk);
  endtask : note

  task automatic fin();
    @(posedge clk);
    {gprWrEn, segWrEn, xferEn, ipWrEn, statusWrEn, dirWrEn, taskSuspend, taskLoad, handlerCall, init} <= '0;
    flagOp <= arf_pkg::ARF_FL_NONE;
  endtask : fin

  task automatic gw(input int i, input int w, input logic [31:0] v);
    @(posedge clk);
    {gprWrEn, gprWrSel, gprWrData} <= {1'b1, i[2:0], v};
    gprWrWidth <= arf_pkg::arf_width_e'(w);
    fin();
  endtask : gw

  task automatic gr(input int i, input int w, input logic [31:0] e);
    @(posedge clk);
    gprRdSel <= i[2:0];
    gprRdWidth <= arf_pkg::arf_width_e'(w);
    fin();
    note(0, e);
  endtask : gr

  task automatic sr(input int s, input logic [15:0] e);
    @(posedge clk);
    segRdSel <= s[2:0];
    fin();
    note(1, {16'h0, e});
  endtask : sr

  // m = suspend, load, handler, init, dir, status
  task automatic act(input logic [5:0] m, input arf_pkg::arf_flop_e o, input logic [31:0] v);
    @(posedge clk);
    {taskSuspend, taskLoad, handlerCall, init, dirWrEn, statusWrEn} <= m;
    {statusWrData, dirWrData, flagPopData} <= {v, v[10], v};
    flagOp <= o;
    fin();
  endtask : act

  always @(negedge clk) if (kQ.size() > 0) chk(expQ.pop_front(), pick(kQ.pop_front()));

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      miscompares++;
      close_out();
    end
  end

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    {rstn, init, gprWrEn, segWrEn, xferEn, ipWrEn, statusWrEn, dirWrEn, dirWrData, taskSuspend} = '0;
    {taskLoad, handlerCall, handlerViaTask, gprRdSel, gprWrSel, segRdSel, segWrSel, gprWrData, segWrData} = '0;
    {xferCodeSel, xferIp, ipWrData, flagPopData, statusWrData} = '0;
    gprRdWidth = arf_pkg::ARF_W32;
    gprWrWidth = arf_pkg::ARF_W32;
    flagOp = arf_pkg::ARF_FL_NONE;
    foreach (gpr[i]) {gpr[i], seg[i]} = '0;
    void'($urandom(32'h195c));
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    fl = arf_pkg::FLAGS_RESET;
    note(2, fl);
    for (int i = 0; i < 8; i++) begin
      for (int w = 0; w < 4; w++) begin
        d = $urandom();
        gw(i, w, d);
        note(6, (w > 1 && i > 3) ? 32'h2 : 32'h0);
        if (w == 0) gpr[i] = d;
        if (w == 1) gpr[i][15:0] = d[15:0];
        if (w == 2 && i < 4) gpr[i][7:0] = d[7:0];
        if (w == 3 && i < 4) gpr[i][15:8] = d[7:0];
        gr(i, 0, gpr[i]);
        gr(i, w, aview(gpr[i], i, w));
      end
    end
    foreach (vmap[j]) note(9 + j, gpr[vmap[j]]);
    for (int s = 0; s < 8; s++) begin
      sr(s, seg[s]);
      d = $urandom();
      @(posedge clk);
      {segWrEn, segWrSel, segWrData} <= {1'b1, s[2:0], d[15:0]};
      fin();
      note(6, (s == 1 || s > 5) ? 32'h1 : 32'h0);
      if (s != 1 && s < 6) seg[s] = d[15:0];
      sr(s, seg[s]);
    end
    note(7, {seg[2], seg[3]});
    note(8, {seg[0], 16'h0});
    d = $urandom();
    @(posedge clk);
    {xferEn, ipWrEn, xferCodeSel, xferIp, ipWrData} <= {2'b11, d[31:16], d, ~d};
    fin();
    note(3, d);
    act(6'h01, arf_pkg::ARF_FL_NONE, d);
    fl = (fl & ~arf_pkg::FLAGS_STATUS) | (d & arf_pkg::FLAGS_STATUS);
    note(2, fl);
    act(6'h02, arf_pkg::ARF_FL_NONE, 32'h400);
    fl[10] = 1'b1;
    note(14, 32'h1);
    act(6'h00, arf_pkg::ARF_FL_LOAD_TO_ACC, 32'h0);
    gpr[0][15:8] = fl[7:0];
    gr(0, 0, gpr[0]);
    d = $urandom();
    gw(0, 3, d);
    act(6'h00, arf_pkg::ARF_FL_STORE_FROM_ACC, 32'h0);
    fl = (fl & ~arf_pkg::FLAGS_LOBYTE) | ({24'h0, d[7:0]} & arf_pkg::FLAGS_LOBYTE);
    note(2, fl);
    act(6'h00, arf_pkg::ARF_FL_PUSH_DWORD, 32'h0);
    note(4, fl);
    act(6'h00, arf_pkg::ARF_FL_PUSH_WORD, 32'h0);
    note(15, fl & arf_pkg::FLAGS_WORD);
    act(6'h08, arf_pkg::ARF_FL_NONE, 32'h0);
    note(4, fl);
    note(16, fl);
    act(6'h20, arf_pkg::ARF_FL_NONE, 32'h0);
    note(5, fl);
    sv = fl;
    d = $urandom();
    act(6'h00, arf_pkg::ARF_FL_POP_DWORD, d);
    fl = (d & ~arf_pkg::FLAGS_RSVD) | arf_pkg::FLAGS_RESET;
    note(2, fl);
    d = $urandom();
    act(6'h00, arf_pkg::ARF_FL_POP_WORD, d);
    fl = (fl & ~arf_pkg::FLAGS_WORD) | (d & arf_pkg::FLAGS_WORD & ~arf_pkg::FLAGS_RSVD) | arf_pkg::FLAGS_RESET;
    note(2, fl);
    act(6'h10, arf_pkg::ARF_FL_NONE, 32'h0);
    note(2, sv);
    @(posedge clk);
    handlerViaTask <= 1'b1;
    act(6'h08, arf_pkg::ARF_FL_NONE, 32'h0);
    note(5, sv);
    @(posedge clk);
    handlerViaTask <= 1'b0;
    act(6'h04, arf_pkg::ARF_FL_NONE, 32'h0);
    note(2, arf_pkg::FLAGS_RESET);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    note(2, arf_pkg::FLAGS_RESET);
    gr(0, 0, arf_pkg::GPR_RESET);
    close_out();
  end
endmodule : arf_register_file_tb
